// ### rtl/mdg_general_regs.sv
`timescale 1ns/1ns
// Operation
// - Config bit 0 selects direct drive
// - Config bit 1 drops charge-pump switching delays
// - Config bit 2 mirrors bridge A, parallel
// - Config bit 7 routes analog test to pin
// - Status write one clears, zero keeps
// - Status bit 0 set after reset
// - Status bit 1 latches driver shutdown
// - Fault clear refused while condition present
// - Status bit 2 live low supply
// - Counter increments per accepted write
// - Reads never change the counter
// - Counter wraps 255 to 0
// - Address top bit set means write
// - All registers reset to zero except status bit 0, which resets to one
// - Only good CRC, own address count
module mdg_general_regs
  import mdg_pkg::*;
(
  input wire logic clock,              // System clock, 100 MHz
  input wire logic rst,                // Synchronous reset, high
  input wire mdg_acc_t acc,            // Access from serial front end
  input wire logic ot_fault,           // Overtemperature condition live
  input wire logic short_fault,        // Short-circuit condition live
  input wire logic drv_shutdown,       // Pulse: driver shut down
  input wire logic low_supply_flag,    // Supply comparator, high below 3.5V
  input wire logic [1:0] hold_current_field, // Low bits of hold current
  output logic [31:0] rd_data,         // Read reply data
  output logic rd_valid,               // Pulse: reply data ready
  output mdg_mode_t mode,              // Mode controls to the bridges
  output logic [MDG_RC_WIDTH-1:0] reply_config, // Reply config field
  output logic test_route_en,          // Analog test on direction pin
  output logic [1:0] test_select       // Analog test source
);

  logic good_acc;     // Accepted datagram
  logic is_write;     // Accepted write
  logic is_read;      // Accepted read
  logic [6:0] reg_addr; // Register address
  logic gs_clr_rst;   // Clear request, reset flag
  logic gs_clr_err;   // Clear request, fault flag
  logic fault_live;   // Any fault cause present
  logic gs_rst_flag;  // Reset flag state
  logic gs_err_flag;  // Fault flag state
  logic [7:0] wcount; // Write counter value

  logic [MDG_GC_WIDTH-1:0] gcfg_q; // Global config
  logic [MDG_GC_WIDTH-1:0] gcfg_d;
  logic [MDG_RC_WIDTH-1:0] rconf_q; // Reply config
  logic [MDG_RC_WIDTH-1:0] rconf_d;
  logic [31:0] rd_data_q;           // Reply data
  logic [31:0] rd_data_d;
  logic rd_valid_q;                 // Reply strobe
  logic rd_valid_d;
  mdg_mode_t mode_q;                // Registered mode outputs
  mdg_mode_t mode_d;
  logic test_en_q;                  // Registered test route
  logic test_en_d;
  logic [1:0] test_sel_q;           // Registered test select
  logic [1:0] test_sel_d;

  // Corrupt or foreign datagrams are dropped entirely
  assign good_acc = acc.valid && acc.crc_ok && acc.addr_ok;
  assign is_write = good_acc && acc.addr[MDG_WRITE_BIT];
  assign is_read = good_acc && !acc.addr[MDG_WRITE_BIT];
  assign reg_addr = acc.addr[6:0];

  // Write-one-to-clear strobes for status
  assign gs_clr_rst = is_write && reg_addr == MDG_ADDR_GSTS && acc.data[MDG_GS_RESET];
  assign gs_clr_err = is_write && reg_addr == MDG_ADDR_GSTS && acc.data[MDG_GS_DRVERR];
  assign fault_live = ot_fault || short_fault;

  // Reset flag comes up set, only a clear takes it down
  mdg_w1c_flag #(
    .RESET_VAL(MDG_GS_RESET_VAL[0])
  ) u_flag_reset (
    .clock(clock),
    .rst(rst),
    .set(1'b0),
    .clr(gs_clr_rst),
    .hold(1'b0),
    .flag(gs_rst_flag)
  );

  // Fault flag held while any cause remains
  mdg_w1c_flag #(
    .RESET_VAL(1'b0)
  ) u_flag_err (
    .clock(clock),
    .rst(rst),
    .set(drv_shutdown),
    .clr(gs_clr_err),
    .hold(fault_live),
    .flag(gs_err_flag)
  );

  // Only writes step the counter; reads pass it by
  mdg_wr_counter #(
    .WIDTH(8)
  ) u_wcount (
    .clock(clock),
    .rst(rst),
    .inc(is_write),
    .count(wcount)
  );

  // Config and reply register next values
  always_comb
  begin
    gcfg_d = gcfg_q;
    rconf_d = rconf_q;
    if (is_write && reg_addr == MDG_ADDR_GCFG)
    begin
      // Reserved and undescribed bits are forced to zero
      gcfg_d = acc.data[MDG_GC_WIDTH-1:0] & MDG_GC_MASK;
    end
    if (is_write && reg_addr == MDG_ADDR_RCONF)
    begin
      rconf_d = acc.data[MDG_RC_WIDTH-1:0];
    end
  end

  // Read reply mux; reply config is write only and reads zero
  always_comb
  begin
    rd_data_d = 32'h0000_0000;
    rd_valid_d = is_read;
    if (is_read)
    begin
      unique case (reg_addr)
        MDG_ADDR_GCFG: rd_data_d = {22'h00_0000, gcfg_q};
        MDG_ADDR_GSTS: rd_data_d = {29'h0000_0000, low_supply_flag, gs_err_flag, gs_rst_flag};
        MDG_ADDR_WCNT: rd_data_d = {24'h00_0000, wcount};
        default: rd_data_d = 32'h0000_0000; // Unmapped or write-only
      endcase
    end
  end

  // Mode outputs derived from config
  always_comb
  begin
    mode_d.direct = gcfg_d[MDG_GC_DIRECT];
    mode_d.extcap = gcfg_d[MDG_GC_EXTCAP];
    mode_d.par = gcfg_d[MDG_GC_PAR];
    mode_d.test = gcfg_d[MDG_GC_TEST];
    test_en_d = gcfg_d[MDG_GC_TEST];
    test_sel_d = gcfg_d[MDG_GC_TEST] ? hold_current_field : 2'h0;
  end

  // Register everything
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      gcfg_q <= MDG_GC_RESET;
      rconf_q <= MDG_RC_RESET;
      rd_data_q <= 32'h0000_0000;
      rd_valid_q <= 1'b0;
      mode_q <= '0;
      test_en_q <= 1'b0;
      test_sel_q <= 2'h0;
    end
    else
    begin
      gcfg_q <= gcfg_d;
      rconf_q <= rconf_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      mode_q <= mode_d;
      test_en_q <= test_en_d;
      test_sel_q <= test_sel_d;
    end
  end

  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign mode = mode_q;
  assign reply_config = rconf_q;
  assign test_route_en = test_en_q;
  assign test_select = test_sel_q;

  // Helpers: counter, input, write data and config values one cycle back
  logic [7:0] wcount_past; // Previous counter
  logic past_ok;           // History valid
  logic [1:0] hold_past;   // Previous test source
  logic supply_past;       // Previous comparator level
  logic [MDG_GC_WIDTH-1:0] cfg_wr_past; // Previous masked write data
  logic [MDG_RC_WIDTH-1:0] rc_wr_past;  // Previous reply write data
  logic [MDG_GC_WIDTH-1:0] gcfg_past;   // Previous config
  // History for the checks; no reset needed, guarded by past_ok or antecedents
  always_ff @(posedge clock)
  begin
    wcount_past <= wcount;
    past_ok <= !rst;
    hold_past <= hold_current_field;
    supply_past <= low_supply_flag;
    cfg_wr_past <= acc.data[MDG_GC_WIDTH-1:0] & MDG_GC_MASK;
    rc_wr_past <= acc.data[MDG_RC_WIDTH-1:0];
    gcfg_past <= gcfg_q;
  end

  a_cnt_step_write: assert property (@(posedge clock) disable iff (rst)
    is_write |=> wcount == 8'(wcount_past + 8'h01))
    else $error("counter did not step on write");

  a_cnt_read_hold: assert property (@(posedge clock) disable iff (rst)
    (good_acc && !is_write) |=> wcount == wcount_past)
    else $error("counter changed without write");

  a_cnt_wrap: assert property (@(posedge clock) disable iff (rst)
    (is_write && wcount == 8'hFF) |=> wcount == 8'h00)
    else $error("counter did not wrap");

  a_bad_crc_ignored: assert property (@(posedge clock) disable iff (rst)
    (acc.valid && !acc.crc_ok) |=> $stable(wcount) && $stable(gcfg_q))
    else $error("bad datagram took effect");

  a_rst_flag_set: assert property (@(posedge clock)
    $fell(rst) |-> gs_rst_flag)
    else $error("reset flag not set after reset");

  a_err_clear_block: assert property (@(posedge clock) disable iff (rst)
    (gs_err_flag && fault_live) |=> gs_err_flag)
    else $error("fault flag cleared with cause present");

  a_err_latch: assert property (@(posedge clock) disable iff (rst)
    drv_shutdown |=> gs_err_flag)
    else $error("fault flag did not latch");

  a_w1c_clear: assert property (@(posedge clock) disable iff (rst)
    (gs_clr_rst) |=> !gs_rst_flag)
    else $error("reset flag not cleared by write one");

  a_par_mode_out: assert property (@(posedge clock) disable iff (rst)
    past_ok |-> mode.par == gcfg_q[MDG_GC_PAR] && mode.direct == gcfg_q[MDG_GC_DIRECT])
    else $error("mode outputs disagree with config");

  a_reserved_zero: assert property (@(posedge clock) disable iff (rst)
    (gcfg_q & ~MDG_GC_MASK) == 10'h000)
    else $error("reserved config bits set");

  a_test_route: assert property (@(posedge clock) disable iff (rst)
    past_ok |-> test_route_en == gcfg_q[MDG_GC_TEST])
    else $error("test route disagrees with config");

  // Reply strobe follows every accepted read by one cycle
  a_rd_valid_pulse: assert property (@(posedge clock) disable iff (rst)
    is_read |=> rd_valid)
    else $error("no reply after read");

  // Writes never produce a reply
  a_wr_no_reply: assert property (@(posedge clock) disable iff (rst)
    is_write |=> !rd_valid)
    else $error("reply after write");

  // Dropped datagrams leave no reply behind
  a_drop_no_reply: assert property (@(posedge clock) disable iff (rst)
    !good_acc |=> !rd_valid)
    else $error("reply without accepted read");

  // Reply bus is quiet between replies
  a_rd_idle_zero: assert property (@(posedge clock) disable iff (rst)
    !rd_valid |-> rd_data == 32'h0000_0000)
    else $error("reply data outside strobe");

  a_cfg_read_back: assert property (@(posedge clock) disable iff (rst)
    (is_read && reg_addr == MDG_ADDR_GCFG) |=> rd_data == {22'h00_0000, gcfg_past})
    else $error("config read back wrong");

  a_cnt_read_back: assert property (@(posedge clock) disable iff (rst)
    (is_read && reg_addr == MDG_ADDR_WCNT) |=> rd_data == {24'h00_0000, wcount_past})
    else $error("counter read back wrong");

  // Supply bit is the live comparator, not a latch
  a_supply_live: assert property (@(posedge clock) disable iff (rst)
    (is_read && reg_addr == MDG_ADDR_GSTS) |=> rd_data[MDG_GS_LOWSUP] == supply_past)
    else $error("supply bit not live");

  a_wo_read_zero: assert property (@(posedge clock) disable iff (rst)
    (is_read && reg_addr == MDG_ADDR_RCONF) |=> rd_data == 32'h0000_0000)
    else $error("write-only register read nonzero");

  a_cfg_write_lands: assert property (@(posedge clock) disable iff (rst)
    (is_write && reg_addr == MDG_ADDR_GCFG) |=> gcfg_q == cfg_wr_past)
    else $error("config write lost");

  a_rconf_write: assert property (@(posedge clock) disable iff (rst)
    (is_write && reg_addr == MDG_ADDR_RCONF) |=> reply_config == rc_wr_past)
    else $error("reply config write lost");

  a_extcap_mode: assert property (@(posedge clock) disable iff (rst)
    past_ok |-> mode.extcap == gcfg_q[MDG_GC_EXTCAP])
    else $error("capacitor mode disagrees with config");

  // Source select is sampled together with the config edge
  a_test_select: assert property (@(posedge clock) disable iff (rst)
    past_ok |-> test_select == (gcfg_q[MDG_GC_TEST] ? hold_past : 2'h0))
    else $error("test source select wrong");

  // Writing zero must not disturb a set flag
  a_w1c_keep: assert property (@(posedge clock) disable iff (rst)
    (is_write && reg_addr == MDG_ADDR_GSTS && !acc.data[MDG_GS_RESET] && gs_rst_flag) |=> gs_rst_flag)
    else $error("reset flag lost on write zero");

  // Clear goes through once every cause is gone and no new event arrives
  a_err_clear_ok: assert property (@(posedge clock) disable iff (rst)
    (gs_clr_err && !fault_live && !drv_shutdown) |=> !gs_err_flag)
    else $error("fault flag not cleared");

  // Mode, reply strobe, reply config and test route idle at the first edge after reset
  a_reset_outputs: assert property (@(posedge clock)
    $fell(rst) |-> {mode, rd_valid, reply_config, test_route_en} == 10'h000)
    else $error("outputs not idle after reset");

endmodule : mdg_general_regs

// ### rtl/mdg_pkg.sv
package mdg_pkg;

  // Register addresses on the serial link (7-bit field)
  localparam logic [6:0] MDG_ADDR_GCFG = 7'h00;
  localparam logic [6:0] MDG_ADDR_GSTS = 7'h01;
  localparam logic [6:0] MDG_ADDR_WCNT = 7'h02;
  localparam logic [6:0] MDG_ADDR_RCONF = 7'h03;

  // Write flag is the top bit of the address byte
  localparam int MDG_WRITE_BIT = 7;

  // Global configuration field positions
  localparam int MDG_GC_DIRECT = 0;
  localparam int MDG_GC_EXTCAP = 1;
  localparam int MDG_GC_PAR = 2;
  localparam int MDG_GC_TEST = 7;
  localparam int MDG_GC_WIDTH = 10;
  // Writable bits of global configuration; reserved 3..5 and undescribed bits stay zero
  localparam logic [9:0] MDG_GC_MASK = 10'h087;

  // Global status field positions
  localparam int MDG_GS_RESET = 0;
  localparam int MDG_GS_DRVERR = 1;
  localparam int MDG_GS_LOWSUP = 2;

  // Reply configuration width
  localparam int MDG_RC_WIDTH = 4;

  // Reset values
  localparam logic [9:0] MDG_GC_RESET = 10'h000;
  localparam logic [1:0] MDG_GS_RESET_VAL = 2'h1;
  localparam logic [7:0] MDG_WCNT_RESET = 8'h00;
  localparam logic [3:0] MDG_RC_RESET = 4'h0;

  // Analog test selector code on hold current low bits
  localparam logic [1:0] MDG_TEST_TEMP_DAC = 2'h1;

  // One register access taken from the serial front end
  typedef struct packed {
    logic valid;       // Datagram complete
    logic crc_ok;      // CRC matched
    logic addr_ok;     // Own slave address matched
    logic [7:0] addr;  // Write flag plus register address
    logic [31:0] data; // Write data
  } mdg_acc_t;

  // Mode controls that steer the bridges
  typedef struct packed {
    logic direct;      // Direct drive
    logic extcap;      // Charge-pump capacitor fitted
    logic par;         // Parallel single motor
    logic test;        // Analog test output
  } mdg_mode_t;

endpackage : mdg_pkg

// ### rtl/mdg_w1c_flag.sv
`timescale 1ns/1ns
// Sticky flag: set wins over clear, clear may be blocked
module mdg_w1c_flag
  import mdg_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0 // Value after reset
)
(
  input wire logic clock,   // System clock
  input wire logic rst,     // Synchronous reset
  input wire logic set,     // Event sets the flag
  input wire logic clr,     // Write one clears
  input wire logic hold,    // Cause still present, refuse clear
  output logic flag         // Latched flag
);

  logic flag_q; // Flag state
  logic flag_d; // Next state

  // Set has priority so an event in the clear cycle survives
  always_comb
  begin
    flag_d = flag_q;
    if (clr && !hold)
    begin
      flag_d = 1'b0;
    end
    if (set)
    begin
      flag_d = 1'b1;
    end
  end

  // Register
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      flag_q <= RESET_VAL;
    end
    else
    begin
      flag_q <= flag_d;
    end
  end

  assign flag = flag_q;

endmodule : mdg_w1c_flag

// ### rtl/mdg_wr_counter.sv
`timescale 1ns/1ns
// Wrapping counter of accepted writes
module mdg_wr_counter
  import mdg_pkg::*;
#(
  parameter int WIDTH = 8 // Counter width
)
(
  input wire logic clock,           // System clock
  input wire logic rst,             // Synchronous reset
  input wire logic inc,             // One accepted write
  output logic [WIDTH-1:0] count    // Current count
);

  logic [WIDTH-1:0] count_q; // Count state
  logic [WIDTH-1:0] count_d; // Next count

  // Natural overflow wraps the maximum back to zero
  always_comb
  begin
    count_d = count_q;
    if (inc)
    begin
      count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // Register
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      count_q <= '0;
    end
    else
    begin
      count_q <= count_d;
    end
  end

  assign count = count_q;

endmodule : mdg_wr_counter

// ### test/mdg_host_model.sv
`timescale 1ns/1ns
// Host side: one register access per call towards the block
module mdg_host_model
  import mdg_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic [31:0] rd_data, // Reply data
  input wire logic rd_valid, // Reply strobe
  output mdg_acc_t acc // Access to the block
);
  // Idle bus; stale data is inverted so it is never mistaken for live data
  initial acc = '{valid: 1'b0, crc_ok: 1'b0, addr_ok: 1'b0, addr: 8'h00, data: 32'hA5A5A5A5};

  // One access: pulse for one edge, then a gap edge before the next call
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [31:0] d, input logic crc,
                      input logic own, output logic [31:0] rdata, output logic rv);
    @(posedge clock);
    acc <= '{valid: 1'b1, crc_ok: crc, addr_ok: own, addr: {wr, a}, data: d};
    @(posedge clock);
    acc <= '{valid: 1'b0, crc_ok: 1'b0, addr_ok: 1'b0, addr: ~{wr, a}, data: ~d};
    #1;
    // Reply stands 1 ns after the taking edge, registered on that same edge
    rdata = rd_data;
    rv = rd_valid;
  endtask : xfer
endmodule : mdg_host_model

// ### test/tb.sv
`timescale 1ns/1ns
// Self-checking bench for the general register group
module tb
  import mdg_pkg::*;
;
  logic clock = 1'b0; // System clock
  logic rst = 1'b1; // Reset, held at start
  mdg_acc_t acc; // Access from host model
  logic ot_fault = 1'b0; // Overtemperature cause
  logic short_fault = 1'b0; // Short cause
  logic drv_shutdown = 1'b0; // Shutdown event
  logic low_supply_flag = 1'b0; // Supply comparator
  logic [1:0] hold_current_field = 2'h1; // Test source select
  logic [31:0] rd_data; // Reply data
  logic rd_valid; // Reply strobe
  mdg_mode_t mode; // Bridge modes
  logic [3:0] reply_config; // Reply config
  logic test_route_en; // Test route
  logic [1:0] test_select; // Test source
  int err_count = 0; // Mismatches
  int total_checks = 0; // Comparisons
  logic [31:0] rv_data; // Last reply
  logic rv_ok; // Last strobe
  logic [7:0] exp_cnt = 8'h00; // Expected write count

  // 100 MHz clock
  always #5 clock = ~clock;

  mdg_general_regs mdg_general_regs_inst (.clock(clock), .rst(rst), .acc(acc), .ot_fault(ot_fault),
    .short_fault(short_fault), .drv_shutdown(drv_shutdown), .low_supply_flag(low_supply_flag),
    .hold_current_field(hold_current_field), .rd_data(rd_data), .rd_valid(rd_valid), .mode(mode),
    .reply_config(reply_config), .test_route_en(test_route_en), .test_select(test_select));

  mdg_host_model mdg_host_model_inst (.clock(clock), .rd_data(rd_data), .rd_valid(rd_valid), .acc(acc));

  // Value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Good write; every accepted write bumps the expected count
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    mdg_host_model_inst.xfer(1'b1, a, d, 1'b1, 1'b1, rv_data, rv_ok);
    exp_cnt++;
  endtask : wr

  // Read with reply strobe and data check
  task automatic rd_chk(input logic [6:0] a, input logic [31:0] exp, input string what);
    mdg_host_model_inst.xfer(1'b0, a, 32'h0, 1'b1, 1'b1, rv_data, rv_ok);
    chk({31'h0, rv_ok}, 32'h1, "reply strobe");
    chk(rv_data, exp, what);
  endtask : rd_chk

  // Values straight after reset
  task automatic t_reset;
    rd_chk(MDG_ADDR_GCFG, 32'h0, "config reset");
    rd_chk(MDG_ADDR_GSTS, 32'h1, "status reset");
    rd_chk(MDG_ADDR_WCNT, 32'h0, "count reset");
    chk({28'h0, mode}, 32'h0, "mode reset");
    $display("test reset done");
  endtask : t_reset

  // Mode bits, masking and test routing
  task automatic t_config;
    wr(MDG_ADDR_GCFG, 32'hFFFFFFFF);
    rd_chk(MDG_ADDR_GCFG, 32'h087, "config mask");
    chk({28'h0, mode}, 32'hF, "mode all");
    chk({29'h0, test_route_en, test_select}, 32'h5, "test route");
    wr(MDG_ADDR_GCFG, 32'h1);
    chk({28'h0, mode}, 32'h8, "direct only");
    chk({29'h0, test_route_en, test_select}, 32'h0, "test off");
    wr(MDG_ADDR_GCFG, 32'h5);
    chk({28'h0, mode}, 32'hA, "parallel");
    $display("test config done");
  endtask : t_config

  // Sticky flags, refused clear, live supply bit
  task automatic t_status;
    wr(MDG_ADDR_GSTS, 32'h0);
    rd_chk(MDG_ADDR_GSTS, 32'h1, "zero keeps");
    wr(MDG_ADDR_GSTS, 32'h1);
    rd_chk(MDG_ADDR_GSTS, 32'h0, "one clears");
    @(posedge clock);
    ot_fault <= 1'b1;
    drv_shutdown <= 1'b1;
    @(posedge clock);
    drv_shutdown <= 1'b0;
    rd_chk(MDG_ADDR_GSTS, 32'h2, "fault latched");
    wr(MDG_ADDR_GSTS, 32'h2);
    rd_chk(MDG_ADDR_GSTS, 32'h2, "clear refused hot");
    @(posedge clock);
    ot_fault <= 1'b0;
    short_fault <= 1'b1;
    wr(MDG_ADDR_GSTS, 32'h2);
    rd_chk(MDG_ADDR_GSTS, 32'h2, "clear refused short");
    @(posedge clock);
    short_fault <= 1'b0;
    wr(MDG_ADDR_GSTS, 32'h2);
    rd_chk(MDG_ADDR_GSTS, 32'h0, "fault cleared");
    @(posedge clock);
    low_supply_flag <= 1'b1;
    rd_chk(MDG_ADDR_GSTS, 32'h4, "supply low");
    @(posedge clock);
    low_supply_flag <= 1'b0;
    rd_chk(MDG_ADDR_GSTS, 32'h0, "supply ok");
    $display("test status done");
  endtask : t_status

  // Counting, rejects, reads and wrap
  task automatic t_counter;
    rd_chk(MDG_ADDR_WCNT, {24'h0, exp_cnt}, "count writes");
    mdg_host_model_inst.xfer(1'b1, MDG_ADDR_GCFG, 32'h0, 1'b0, 1'b1, rv_data, rv_ok);
    mdg_host_model_inst.xfer(1'b1, MDG_ADDR_GCFG, 32'h0, 1'b1, 1'b0, rv_data, rv_ok);
    rd_chk(MDG_ADDR_GCFG, 32'h5, "rejected writes");
    rd_chk(MDG_ADDR_WCNT, {24'h0, exp_cnt}, "rejects not counted");
    wr(MDG_ADDR_WCNT, 32'h55);
    rd_chk(MDG_ADDR_WCNT, {24'h0, exp_cnt}, "read-only write counted");
    while (exp_cnt != 8'hFF)
      wr(MDG_ADDR_RCONF, 32'h0);
    rd_chk(MDG_ADDR_WCNT, 32'hFF, "count top");
    wr(MDG_ADDR_RCONF, 32'h0);
    rd_chk(MDG_ADDR_WCNT, 32'h0, "count wrap");
    $display("test counter done");
  endtask : t_counter

  // Write-only and unmapped places
  task automatic t_reply;
    wr(MDG_ADDR_RCONF, 32'hA);
    chk({28'h0, reply_config}, 32'hA, "reply config");
    rd_chk(MDG_ADDR_RCONF, 32'h0, "write-only reads zero");
    rd_chk(7'h10, 32'h0, "unmapped reads zero");
    $display("test reply done");
  endtask : t_reply

  // Verdict and end of run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // Main sequence
  initial
  begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_config();
    t_status();
    t_counter();
    t_reply();
    end_sim();
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clock);
    err_count++;
    $display("mismatch at %0t: run did not finish", $time);
    end_sim();
  end
endmodule : tb
